// >>> egb_params.svh
`ifndef EGB_PARAMS_SVH
`define EGB_PARAMS_SVH

// register byte offsets
`define EGB_OFS_CTRL      8'h00
`define EGB_OFS_STATUS    8'h04
`define EGB_OFS_MASK      8'h08
`define EGB_OFS_CAUSE     8'h0C
`define EGB_OFS_IROM_END  8'h10
`define EGB_OFS_IRAM_BASE 8'h14
`define EGB_OFS_STACK     8'h18
`define EGB_OFS_BLKMAP    8'h1C
`define EGB_OFS_PROTECT   8'h20
`define EGB_OFS_SFRMAP    8'h24
`define EGB_OFS_RUNSTATE  8'h28

// control register fields
`define EGB_CTRL_MSEL_LSB 0
`define EGB_CTRL_SSEL     2
`define EGB_CTRL_PBRK     3
`define EGB_CTRL_RMASK    4
`define EGB_CTRL_INIT     5
`define EGB_CTRL_STK_EN   6
`define EGB_CTRL_PROT_EN  7

// status / mask fields
`define EGB_ST_GUARD      0
`define EGB_ST_TRST       1

// sfr map write fields
`define EGB_SFR_IDX_LSB   0
`define EGB_SFR_ATTR_LSB  8

// special register window starts here
`define EGB_SFR_BASE      16'hFF00

// reset values
`define EGB_RST_IROM_END  16'h0000
`define EGB_RST_IRAM_BASE 16'hFF00
`define EGB_RST_BLKMAP    16'h0000

`endif

// >>> egb_pkg.sv
package egb_pkg;

  // access kind presented by the emulation cpu
  typedef enum logic [1:0] {
    EGB_FETCH,
    EGB_READ,
    EGB_WRITE,
    EGB_STACK
  } egb_acc_t;

  // per 8k block attribute
  typedef enum logic [1:0] {
    EGB_BLK_NONE,
    EGB_BLK_EROM,
    EGB_BLK_ERAM,
    EGB_BLK_TARGET
  } egb_blk_t;

  // per special register location
  typedef enum logic [1:0] {
    EGB_SFR_NONE,
    EGB_SFR_RW,
    EGB_SFR_RO,
    EGB_SFR_WO
  } egb_sfr_t;

  // main clock source
  typedef enum logic [1:0] {
    EGB_MCLK_5M,
    EGB_MCLK_10M,
    EGB_MCLK_ALT,
    EGB_MCLK_USER
  } egb_mclk_t;

  // region class of the checked address, part of the cause code
  typedef enum logic [3:0] {
    EGB_CLS_IROM,
    EGB_CLS_IRAM,
    EGB_CLS_PROTECT,
    EGB_CLS_UNMAPPED,
    EGB_CLS_EROM,
    EGB_CLS_ERAM,
    EGB_CLS_TARGET,
    EGB_CLS_SFR_NONE,
    EGB_CLS_SFR_RW,
    EGB_CLS_SFR_RO,
    EGB_CLS_SFR_WO
  } egb_cls_t;

endpackage : egb_pkg

// >>> egb_sfr_map.sv
`timescale 1ns/1ps
module egb_sfr_map (
  input  wire logic             clk_i,
  input  wire logic             we_i,
  input  wire logic [7:0]       waddr_i,
  input  wire egb_pkg::egb_sfr_t wdata_i,
  input  wire logic             re_i,
  input  wire logic [7:0]       raddr_i,
  output egb_pkg::egb_sfr_t     rdata_o
);
  import egb_pkg::*;

  // no reset on the array: the host loads it during initialisation
  egb_sfr_t mem_q [256];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (re_i) begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule : egb_sfr_map

// >>> egb_guard.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "egb_params.svh"
module egb_guard (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   irq_o,
  // emulation cpu access bus
  input  wire logic              acc_valid_i,
  input  wire logic [15:0]       acc_addr_i,
  input  wire egb_pkg::egb_acc_t acc_type_i,
  input  wire logic              cpu_running_i,
  output logic                   break_req_o,
  output logic                   cpu_reset_o,
  output logic                   periph_halt_o,
  // clock sources and probe pins
  input  wire logic              clk_5m_src_i,
  input  wire logic              clk_10m_src_i,
  input  wire logic              clk_alt_src_i,
  input  wire logic              probe_main_clk_i,
  input  wire logic              clk_32k_src_i,
  input  wire logic              probe_sub_clk_i,
  input  wire logic              probe_reset_n_i,
  output logic                   main_osc_input_o,
  output logic                   sub_osc_input_o
);
  import egb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  egb_mclk_t   msel_q;
  logic        ssel_q;
  logic        pbrk_q;
  logic        rmask_q;
  logic        init_q;
  logic        stk_en_q;
  logic        prot_en_q;
  logic [15:0] irom_end_q;
  logic [15:0] iram_base_q;
  logic [15:0] stk_lo_q;
  logic [15:0] stk_hi_q;
  logic [15:0] prot_lo_q;
  logic [15:0] prot_hi_q;
  egb_blk_t    blk_q [8];
  logic [1:0]  sts_q;
  logic [1:0]  msk_q;
  logic [5:0]  cause_q;
  logic [31:0] prdata_q;

  logic        acc_phase;
  logic        wr_en;
  logic        map_hit;
  logic [1:0]  sts_set;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait, read data staged in the setup cycle

  always_comb begin
    unique case (paddr_i)
      `EGB_OFS_CTRL, `EGB_OFS_STATUS, `EGB_OFS_MASK, `EGB_OFS_CAUSE,
      `EGB_OFS_IROM_END, `EGB_OFS_IRAM_BASE, `EGB_OFS_STACK,
      `EGB_OFS_BLKMAP, `EGB_OFS_PROTECT, `EGB_OFS_SFRMAP,
      `EGB_OFS_RUNSTATE: map_hit = 1'b1;
      default:           map_hit = 1'b0;
    endcase
  end

  assign acc_phase = psel_i & penable_i;
  assign wr_en     = acc_phase & pwrite_i & map_hit;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc_phase & ~map_hit;
  assign prdata_o  = prdata_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr_i)
        `EGB_OFS_CTRL: begin
          prdata_q[`EGB_CTRL_MSEL_LSB +: 2] <= msel_q;
          prdata_q[`EGB_CTRL_SSEL]          <= ssel_q;
          prdata_q[`EGB_CTRL_PBRK]          <= pbrk_q;
          prdata_q[`EGB_CTRL_RMASK]         <= rmask_q;
          prdata_q[`EGB_CTRL_INIT]          <= init_q;
          prdata_q[`EGB_CTRL_STK_EN]        <= stk_en_q;
          prdata_q[`EGB_CTRL_PROT_EN]       <= prot_en_q;
        end
        `EGB_OFS_STATUS:    prdata_q[1:0]   <= sts_q;
        `EGB_OFS_MASK:      prdata_q[1:0]   <= msk_q;
        `EGB_OFS_CAUSE:     prdata_q[5:0]   <= cause_q;
        `EGB_OFS_IROM_END:  prdata_q[15:0]  <= irom_end_q;
        `EGB_OFS_IRAM_BASE: prdata_q[15:0]  <= iram_base_q;
        `EGB_OFS_STACK:     prdata_q        <= {stk_hi_q, stk_lo_q};
        `EGB_OFS_BLKMAP: begin
          for (int i = 0; i < 8; i++) begin
            prdata_q[2*i +: 2] <= blk_q[i];
          end
        end
        `EGB_OFS_PROTECT:   prdata_q        <= {prot_hi_q, prot_lo_q};
        `EGB_OFS_RUNSTATE:  prdata_q[0]     <= cpu_running_i;
        default:            prdata_q        <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msel_q    <= EGB_MCLK_5M;
      ssel_q    <= 1'b0;
      pbrk_q    <= 1'b0;
      rmask_q   <= 1'b0;
      init_q    <= 1'b0;
      stk_en_q  <= 1'b0;
      prot_en_q <= 1'b0;
    end else if (wr_en && paddr_i == `EGB_OFS_CTRL) begin
      msel_q    <= egb_mclk_t'(pwdata_i[`EGB_CTRL_MSEL_LSB +: 2]);
      ssel_q    <= pwdata_i[`EGB_CTRL_SSEL];
      rmask_q   <= pwdata_i[`EGB_CTRL_RMASK];
      stk_en_q  <= pwdata_i[`EGB_CTRL_STK_EN];
      prot_en_q <= pwdata_i[`EGB_CTRL_PROT_EN];
      // only reset clears init, so the option stays put until reinit
      if (!init_q) begin
        pbrk_q <= pwdata_i[`EGB_CTRL_PBRK];
        init_q <= pwdata_i[`EGB_CTRL_INIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory map registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irom_end_q  <= `EGB_RST_IROM_END;
      iram_base_q <= `EGB_RST_IRAM_BASE;
      stk_lo_q    <= 16'h0000;
      stk_hi_q    <= 16'h0000;
      prot_lo_q   <= 16'h0000;
      prot_hi_q   <= 16'h0000;
    end else if (wr_en) begin
      unique case (paddr_i)
        `EGB_OFS_IROM_END:  irom_end_q  <= pwdata_i[15:0];
        `EGB_OFS_IRAM_BASE: iram_base_q <= pwdata_i[15:0];
        `EGB_OFS_STACK: begin
          // a single bound pair, so one stack area only
          stk_lo_q <= pwdata_i[15:0];
          stk_hi_q <= pwdata_i[31:16];
        end
        `EGB_OFS_PROTECT: begin
          prot_lo_q <= pwdata_i[15:0];
          prot_hi_q <= pwdata_i[31:16];
        end
        default: begin
        end
      endcase
    end
  end

  // whole blocks only: widening to 8k bounds is implicit in the index
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        blk_q[i] <= egb_blk_t'(2'(`EGB_RST_BLKMAP >> (2*i)));
      end
    end else if (wr_en && paddr_i == `EGB_OFS_BLKMAP) begin
      for (int i = 0; i < 8; i++) begin
        blk_q[i] <= egb_blk_t'(pwdata_i[2*i +: 2]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access check, stage 1: capture and look up special register map

  logic        s_vld_q;
  logic [15:0] s_addr_q;
  egb_acc_t    s_type_q;
  egb_sfr_t    sfr_attr;

  egb_sfr_map u_sfr_map (
    .clk_i   (clk_i),
    .we_i    (wr_en && paddr_i == `EGB_OFS_SFRMAP),
    .waddr_i (pwdata_i[`EGB_SFR_IDX_LSB +: 8]),
    .wdata_i (egb_sfr_t'(pwdata_i[`EGB_SFR_ATTR_LSB +: 2])),
    .re_i    (acc_valid_i),
    .raddr_i (acc_addr_i[7:0]),
    .rdata_o (sfr_attr)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_vld_q  <= 1'b0;
      s_addr_q <= 16'h0000;
      s_type_q <= EGB_FETCH;
    end else begin
      s_vld_q <= acc_valid_i;
      if (acc_valid_i) begin
        s_addr_q <= acc_addr_i;
        s_type_q <= acc_type_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access check, stage 2: classify and qualify

  egb_cls_t cls;
  logic     viol;
  logic     is_stk;
  logic     is_wr;
  logic     stk_ok;

  // stack kind is tagged by the cpu for call, return, push and pop
  assign is_stk = (s_type_q == EGB_STACK);
  assign is_wr  = (s_type_q == EGB_WRITE);
  assign stk_ok = stk_en_q ? (s_addr_q >= stk_lo_q && s_addr_q <= stk_hi_q)
                           : 1'b1;

  always_comb begin
    cls  = EGB_CLS_UNMAPPED;
    viol = 1'b0;
    if (s_addr_q >= `EGB_SFR_BASE) begin
      unique case (sfr_attr)
        EGB_SFR_NONE: begin
          cls  = EGB_CLS_SFR_NONE;
          viol = 1'b1;
        end
        EGB_SFR_RW: begin
          cls  = EGB_CLS_SFR_RW;
          viol = is_stk;
        end
        EGB_SFR_RO: begin
          cls  = EGB_CLS_SFR_RO;
          viol = is_wr | is_stk;
        end
        EGB_SFR_WO: begin
          cls  = EGB_CLS_SFR_WO;
          viol = (s_type_q != EGB_WRITE);
        end
      endcase
    end else if (prot_en_q && s_addr_q >= prot_lo_q && s_addr_q <= prot_hi_q) begin
      // protect sits above the block attribute it trims
      cls  = EGB_CLS_PROTECT;
      viol = 1'b1;
    end else if (s_addr_q < irom_end_q) begin
      cls  = EGB_CLS_IROM;
      viol = is_wr | is_stk;
    end else if (s_addr_q >= iram_base_q) begin
      cls  = EGB_CLS_IRAM;
      viol = is_stk & ~stk_ok;
    end else begin
      unique case (blk_q[s_addr_q[15:13]])
        EGB_BLK_NONE: begin
          cls  = EGB_CLS_UNMAPPED;
          viol = 1'b1;
        end
        EGB_BLK_EROM: begin
          cls  = EGB_CLS_EROM;
          viol = is_wr | is_stk;
        end
        EGB_BLK_ERAM: begin
          cls  = EGB_CLS_ERAM;
          viol = is_stk & ~stk_ok;
        end
        EGB_BLK_TARGET: begin
          cls  = EGB_CLS_TARGET;
          viol = is_stk & ~stk_ok;
        end
      endcase
    end
  end

  // combinational so the cpu stops on the qualifying cycle itself
  assign break_req_o = s_vld_q & viol;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_q <= 6'h00;
    end else if (break_req_o) begin
      cause_q <= {cls, s_type_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // target reset and peripheral halt

  logic trst_hit;

  // stopped cpu ignores it; a level still low at resume hits once running
  assign trst_hit = ~rmask_q & cpu_running_i & ~probe_reset_n_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_reset_o   <= 1'b0;
      periph_halt_o <= 1'b0;
    end else begin
      cpu_reset_o   <= trst_hit;
      periph_halt_o <= pbrk_q & ~cpu_running_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator routing, retimed on clk_i (sources well below 20 MHz)

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_osc_input_o <= 1'b0;
      sub_osc_input_o  <= 1'b0;
    end else begin
      unique case (msel_q)
        EGB_MCLK_5M:   main_osc_input_o <= clk_5m_src_i;
        EGB_MCLK_10M:  main_osc_input_o <= clk_10m_src_i;
        EGB_MCLK_ALT:  main_osc_input_o <= clk_alt_src_i;
        EGB_MCLK_USER: main_osc_input_o <= probe_main_clk_i;
      endcase
      sub_osc_input_o <= ssel_q ? probe_sub_clk_i : clk_32k_src_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: set wins over write-one-to-clear

  assign sts_set[`EGB_ST_GUARD] = break_req_o;
  assign sts_set[`EGB_ST_TRST]  = trst_hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_q <= 2'h0;
    end else if (wr_en && paddr_i == `EGB_OFS_STATUS) begin
      sts_q <= (sts_q & ~pwdata_i[1:0]) | sts_set;
    end else begin
      sts_q <= sts_q | sts_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msk_q <= 2'h0;
    end else if (wr_en && paddr_i == `EGB_OFS_MASK) begin
      msk_q <= pwdata_i[1:0];
    end
  end

  assign irq_o = |(sts_q & msk_q);

endmodule : egb_guard

// >>> egb_guard_asserts.sv
`timescale 1ns/1ps
module egb_guard_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic pwrite_i,
  input wire logic acc_valid_i,
  input wire logic cpu_running_i,
  input wire logic probe_reset_n_i,
  input wire logic clk_5m_src_i,
  input wire logic clk_10m_src_i,
  input wire logic clk_alt_src_i,
  input wire logic probe_main_clk_i,
  input wire logic clk_32k_src_i,
  input wire logic probe_sub_clk_i,
  input wire logic break_req_o,
  input wire logic cpu_reset_o,
  input wire logic periph_halt_o,
  input wire logic irq_o,
  input wire logic main_osc_input_o,
  input wire logic sub_osc_input_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // selection is invisible here, so only judge when all sources agree
  logic m_same;
  logic s_same;
  assign m_same = &{clk_5m_src_i, clk_10m_src_i, clk_alt_src_i, probe_main_clk_i} ||
                  ~|{clk_5m_src_i, clk_10m_src_i, clk_alt_src_i, probe_main_clk_i};
  assign s_same = clk_32k_src_i == probe_sub_clk_i;
  sequence s_stop_pin;
    !cpu_running_i && !probe_reset_n_i;
  endsequence
  sequence s_quiet;
    !acc_valid_i;
  endsequence
  main_osc_a: assert property (!$past(rst_i) && $past(m_same) |->
    main_osc_input_o == $past(clk_5m_src_i)) else $error("main osc off source");
  sub_osc_a: assert property (!$past(rst_i) && $past(s_same) |->
    sub_osc_input_o == $past(clk_32k_src_i)) else $error("sub osc off source");
  halt_stopped_a: assert property (periph_halt_o |-> !$past(cpu_running_i))
    else $error("halt while running");
  reset_run_a: assert property (cpu_reset_o |->
    $past(cpu_running_i) && !$past(probe_reset_n_i)) else $error("cpu reset no cause");
  reset_stop_a: assert property (s_stop_pin |=> !cpu_reset_o)
    else $error("reset taken while stopped");
  break_cause_a: assert property (break_req_o |-> $past(acc_valid_i))
    else $error("break with no access");
  break_quiet_a: assert property (s_quiet |=> !break_req_o)
    else $error("break after idle cycle");
  irq_cause_a: assert property ($rose(irq_o) |-> $past(break_req_o) ||
    $past(psel_i && pwrite_i) || $past(cpu_running_i && !probe_reset_n_i))
    else $error("irq rose with no event");
endmodule : egb_guard_asserts

bind egb_guard egb_guard_asserts i_egb_guard_asserts (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .pwrite_i(pwrite_i),
  .acc_valid_i(acc_valid_i),
  .cpu_running_i(cpu_running_i),
  .probe_reset_n_i(probe_reset_n_i),
  .clk_5m_src_i(clk_5m_src_i),
  .clk_10m_src_i(clk_10m_src_i),
  .clk_alt_src_i(clk_alt_src_i),
  .probe_main_clk_i(probe_main_clk_i),
  .clk_32k_src_i(clk_32k_src_i),
  .probe_sub_clk_i(probe_sub_clk_i),
  .break_req_o(break_req_o),
  .cpu_reset_o(cpu_reset_o),
  .periph_halt_o(periph_halt_o),
  .irq_o(irq_o),
  .main_osc_input_o(main_osc_input_o),
  .sub_osc_input_o(sub_osc_input_o)
);

// >>> egb_cpu_probe.sv
`timescale 1ns/1ps
module egb_cpu_probe (
  input  wire logic         clk_i,
  output logic              acc_valid_o,
  output logic [15:0]       acc_addr_o,
  output egb_pkg::egb_acc_t acc_type_o,
  output logic              running_o,
  output logic              probe_reset_n_o,
  output logic [3:0]        msrc_o,
  output logic [1:0]        ssrc_o
);
  import egb_pkg::*;
  initial begin
    acc_valid_o = 1'b0;
    acc_addr_o = 16'h0000;
    acc_type_o = EGB_FETCH;
    running_o = 1'b1;
    probe_reset_n_o = 1'b1;
    msrc_o = 4'h0;
    ssrc_o = 2'h0;
  end
  //////////////////////////////////////////////////////////////
  // one cycle per access; calls, returns, push, pop go as stack
  task access(input logic [15:0] a, input egb_acc_t t);
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_addr_o <= a;
    acc_type_o <= t;
    @(posedge clk_i);
    acc_valid_o <= 1'b0;
    // released bus must not keep a plausible address
    acc_addr_o <= ~a;
  endtask : access
  task pins(input logic run, input logic rst_n);
    @(posedge clk_i);
    running_o <= run;
    probe_reset_n_o <= rst_n;
  endtask : pins
  task srcs(input logic [3:0] m, input logic [1:0] s);
    @(posedge clk_i);
    msrc_o <= m;
    ssrc_o <= s;
  endtask : srcs
endmodule : egb_cpu_probe

// >>> tb_top.sv
`timescale 1ns/1ps
`include "egb_params.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  import egb_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, irq_o, acc_valid_i, cpu_running_i;
  logic        break_req_o, cpu_reset_o, periph_halt_o, probe_reset_n_i;
  logic        main_osc_input_o, sub_osc_input_o, err;
  logic [15:0] acc_addr_i;
  egb_acc_t    acc_type_i;
  logic [3:0]  msrc;
  logic [1:0]  ssrc;
  logic [31:0] rd;
  int          mismatches = 0;
  int          cmp_count = 0;
  always #12.5 clk_i = ~clk_i;
  egb_guard i_egb_guard (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i), .acc_type_i(acc_type_i),
    .cpu_running_i(cpu_running_i), .break_req_o(break_req_o), .cpu_reset_o(cpu_reset_o),
    .periph_halt_o(periph_halt_o), .clk_5m_src_i(msrc[0]), .clk_10m_src_i(msrc[1]),
    .clk_alt_src_i(msrc[2]), .probe_main_clk_i(msrc[3]), .clk_32k_src_i(ssrc[0]),
    .probe_sub_clk_i(ssrc[1]), .probe_reset_n_i(probe_reset_n_i),
    .main_osc_input_o(main_osc_input_o), .sub_osc_input_o(sub_osc_input_o));
  egb_cpu_probe i_egb_cpu_probe (.clk_i(clk_i), .acc_valid_o(acc_valid_i),
    .acc_addr_o(acc_addr_i), .acc_type_o(acc_type_i), .running_o(cpu_running_i),
    .probe_reset_n_o(probe_reset_n_i), .msrc_o(msrc), .ssrc_o(ssrc));
  //////////////////////////////////////////////////////////////
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    // no cycle budget here: only the watchdog ends a stuck wait
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rd_chk
  task chk_acc(input logic [15:0] a, input egb_acc_t t, input logic b);
    i_egb_cpu_probe.access(a, t);
    #1;
    `CHK(break_req_o, b)
  endtask : chk_acc
  // output picked by selector: a value argument would be frozen at the call
  task wait_chk(input logic halt, input logic e);
    repeat (3) @(posedge clk_i);
    #1;
    if (halt) begin
      `CHK(periph_halt_o, e)
    end else begin
      `CHK(cpu_reset_o, e)
    end
  endtask : wait_chk
  //////////////////////////////////////////////////////////////
  // covers well over twice the expected run
  initial begin
    #(25 * 20000);
    mismatches++;
    complete_run();
  end
  initial begin
    logic [1:0] at;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`EGB_OFS_CTRL, 32'h0);
    rd_chk(`EGB_OFS_IRAM_BASE, {16'h0, `EGB_RST_IRAM_BASE});
    rd_chk(`EGB_OFS_RUNSTATE, 32'h1);
    apb(1'b0, 8'h3C, 32'h0);
    `CHK(err, 1'b1)
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `EGB_OFS_CTRL, {29'h0, s[0], s[1:0]});
      i_egb_cpu_probe.srcs(4'h1 << s, 2'h1 << s[0]);
      repeat (3) @(posedge clk_i);
      #1;
      `CHK(main_osc_input_o, 1'b1)
      `CHK(sub_osc_input_o, 1'b1)
      i_egb_cpu_probe.srcs(~(4'h1 << s), ~(2'h1 << s[0]));
      repeat (3) @(posedge clk_i);
      #1;
      `CHK(main_osc_input_o, 1'b0)
      `CHK(sub_osc_input_o, 1'b0)
    end
    apb(1'b1, `EGB_OFS_CTRL, 32'h0);
    apb(1'b1, `EGB_OFS_IROM_END, 32'h0000_8000);
    apb(1'b1, `EGB_OFS_IRAM_BASE, 32'h0000_FE00);
    apb(1'b1, `EGB_OFS_BLKMAP, 32'h0000_2D00);
    // map array has no reset, so every entry is loaded
    for (int i = 0; i < 256; i++) begin
      at = (i == 8) ? EGB_SFR_RW : (i == 16) ? EGB_SFR_RO : (i == 32) ? EGB_SFR_WO : 2'h0;
      apb(1'b1, `EGB_OFS_SFRMAP, {22'h0, at, i[7:0]});
    end
    chk_acc(16'h1000, EGB_FETCH, 1'b0);
    chk_acc(16'h1000, EGB_READ, 1'b0);
    chk_acc(16'h1000, EGB_WRITE, 1'b1);
    chk_acc(16'h7FFF, EGB_STACK, 1'b1);
    chk_acc(16'h8000, EGB_FETCH, 1'b0);
    chk_acc(16'h9FFF, EGB_WRITE, 1'b1);
    chk_acc(16'hA000, EGB_WRITE, 1'b0);
    chk_acc(16'hA000, EGB_STACK, 1'b0);
    chk_acc(16'hDFFF, EGB_STACK, 1'b0);
    chk_acc(16'hFE10, EGB_STACK, 1'b0);
    chk_acc(16'hE000, EGB_READ, 1'b1);
    chk_acc(16'hFF01, EGB_READ, 1'b1);
    chk_acc(16'hFF08, EGB_WRITE, 1'b0);
    chk_acc(16'hFF10, EGB_READ, 1'b0);
    chk_acc(16'hFF10, EGB_WRITE, 1'b1);
    chk_acc(16'hFF20, EGB_WRITE, 1'b0);
    chk_acc(16'hFF20, EGB_READ, 1'b1);
    apb(1'b1, `EGB_OFS_PROTECT, 32'h9FFF_8800);
    apb(1'b1, `EGB_OFS_STACK, 32'hFEFF_FE80);
    apb(1'b1, `EGB_OFS_CTRL, 32'h0000_00C0);
    chk_acc(16'h8800, EGB_FETCH, 1'b1);
    chk_acc(16'h9FFF, EGB_READ, 1'b1);
    chk_acc(16'h87FF, EGB_READ, 1'b0);
    chk_acc(16'hFE80, EGB_STACK, 1'b0);
    chk_acc(16'hFEFF, EGB_STACK, 1'b0);
    chk_acc(16'hFE7F, EGB_STACK, 1'b1);
    chk_acc(16'hC000, EGB_WRITE, 1'b0);
    chk_acc(16'hC000, EGB_STACK, 1'b1);
    rd_chk(`EGB_OFS_CAUSE, {26'h0, EGB_CLS_ERAM, EGB_STACK});
    rd_chk(`EGB_OFS_STATUS, 32'h1);
    `CHK(irq_o, 1'b0)
    apb(1'b1, `EGB_OFS_MASK, 32'h1);
    #1;
    `CHK(irq_o, 1'b1)
    apb(1'b1, `EGB_OFS_STATUS, 32'h1);
    #1;
    `CHK(irq_o, 1'b0)
    i_egb_cpu_probe.pins(1'b1, 1'b0);
    wait_chk(1'b0, 1'b1);
    i_egb_cpu_probe.pins(1'b1, 1'b1);
    apb(1'b1, `EGB_OFS_CTRL, 32'h10);
    i_egb_cpu_probe.pins(1'b1, 1'b0);
    wait_chk(1'b0, 1'b0);
    // stop first, so the unmask never meets a running cpu with the pin low
    i_egb_cpu_probe.pins(1'b0, 1'b0);
    apb(1'b1, `EGB_OFS_CTRL, 32'h0);
    wait_chk(1'b0, 1'b0);
    i_egb_cpu_probe.pins(1'b1, 1'b0);
    wait_chk(1'b0, 1'b1);
    apb(1'b1, `EGB_OFS_CTRL, 32'h28);
    i_egb_cpu_probe.pins(1'b0, 1'b1);
    wait_chk(1'b1, 1'b1);
    apb(1'b1, `EGB_OFS_CTRL, 32'h0);
    rd_chk(`EGB_OFS_CTRL, 32'h28);
    i_egb_cpu_probe.pins(1'b1, 1'b1);
    wait_chk(1'b1, 1'b0);
    // only a full reinit frees the peripheral break option again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b1, `EGB_OFS_CTRL, 32'h08);
    rd_chk(`EGB_OFS_CTRL, 32'h08);
    complete_run();
  end
endmodule : tb_top
